// ---- rtl/dsm_pkg.sv ----
// dsm_pkg: constants shared by the data signal modulator files
// assumes: one 25 MHz system clock, register bus words carry 8 data bits
package dsm_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [11:0] DSM_IDX_CONTROL0     = 12'h897; // enable, invert, level
  localparam logic [11:0] DSM_IDX_CARRIER_CTRL = 12'h898; // polarity and sync
  localparam logic [11:0] DSM_IDX_MOD_SRC      = 12'h899; // keying source select
  localparam logic [11:0] DSM_IDX_LOW_SRC      = 12'h89A; // low carrier select
  localparam logic [11:0] DSM_IDX_HIGH_SRC     = 12'h89B; // high carrier select
  localparam int          DSM_ADDR_W           = 14;      // byte address width

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int DSM_BIT_ENABLE      = 7; // module enable
  localparam int DSM_BIT_OUT_STATE   = 5; // read-only output level
  localparam int DSM_BIT_OUT_INVERT  = 4; // output_invert
  localparam int DSM_BIT_SW_LEVEL    = 0; // software_modulation_source
  localparam int DSM_BIT_HIGH_INVERT = 5; // high_carrier_invert
  localparam int DSM_BIT_HIGH_SYNC   = 4; // high_carrier_sync_enable
  localparam int DSM_BIT_LOW_INVERT  = 1; // low_carrier_invert
  localparam int DSM_BIT_LOW_SYNC    = 0; // low_carrier_sync_enable

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] DSM_RST_CONTROL0     = 8'h00;
  localparam logic [7:0] DSM_RST_CARRIER_CTRL = 8'h00;
  localparam logic [4:0] DSM_RST_MOD_SRC      = 5'h00;
  localparam logic [3:0] DSM_RST_CARRIER_SRC  = 4'h0;

  // ==========================================================================
  // keying source codes
  // ==========================================================================
  localparam logic [4:0] DSM_MSRC_PIN       = 5'h00; // modulator_pin_selector pin
  localparam logic [4:0] DSM_MSRC_SW_LEVEL  = 5'h01; // software level
  localparam logic [4:0] DSM_MSRC_LAST      = 5'h13; // last defined code
  localparam int         DSM_MSRC_COUNT     = 20;    // defined codes
  localparam int         DSM_CARRIER_COUNT  = 16;    // carrier codes
  localparam int         DSM_SYNC_WIDTH     = 23;    // synchronised inputs

endpackage : dsm_pkg

// ---- rtl/dsm_sync.sv ----
// dsm_sync: two flip-flop synchroniser for a bundle of level inputs
// assumes: inputs are independent levels from outside the clock domain
`timescale 1ns/1ps
module dsm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import dsm_pkg::*;

  // ==========================================================================
  // synchroniser stages
  // ==========================================================================
  logic [WIDTH-1:0] meta_reg; // first stage, read only by the second

  // two-stage capture
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : dsm_sync

// ---- rtl/dsm_carrier_path.sv ----
// dsm_carrier_path: sixteen-way carrier select with optional inversion
// assumes: all sources already synchronised to the system clock
`timescale 1ns/1ps
module dsm_carrier_path (
  input  wire logic [15:0] sources,
  input  wire logic [3:0]  select,
  input  wire logic        invert,
  output logic             carrier
);
  import dsm_pkg::*;

  // ==========================================================================
  // selection and polarity
  // ==========================================================================
  logic picked; // raw selected source

  assign picked  = sources[select];
  assign carrier = picked ^ invert;

endmodule : dsm_carrier_path

// ---- rtl/dsm_top.sv ----
// dsm_top: data signal modulator with Avalon-MM register slave
// assumes: source signals arrive asynchronously and are synchronised here;
// the bus master holds each request until waitrequest is seen low
`timescale 1ns/1ps

module dsm_top (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  // avalon-mm slave
  input  wire logic [dsm_pkg::DSM_ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [3:0]                  byteenable,
  input  wire logic [31:0]                 writedata,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  // keying and carrier sources
  input  wire logic                        modulator_pin,
  input  wire logic                        low_carrier_pin,
  input  wire logic                        high_carrier_pin,
  input  wire logic [4:0]                  capture_compare_unit_out,
  input  wire logic [1:0]                  pulse_width_out,
  input  wire logic                        numeric_oscillator_out,
  input  wire logic                        comparator_one_out,
  input  wire logic                        comparator_two_out,
  input  wire logic [3:0]                  configurable_logic_cell_out,
  input  wire logic [1:0]                  enhanced_serial_port_tx,
  input  wire logic [1:0]                  sync_serial_port_sdo,
  input  wire logic                        fast_internal_oscillator,
  input  wire logic                        reference_clock_output,
  // modulated output
  output logic                             modulated_output_pin
);
  import dsm_pkg::*;

  // ==========================================================================
  // input synchronisation
  // ==========================================================================
  logic [DSM_SYNC_WIDTH-1:0] raw_bundle;  // all asynchronous sources
  logic [DSM_SYNC_WIDTH-1:0] sync_bundle; // after two flip-flops

  assign raw_bundle = {reference_clock_output, fast_internal_oscillator,
                       sync_serial_port_sdo, enhanced_serial_port_tx,
                       configurable_logic_cell_out, comparator_two_out,
                       comparator_one_out, numeric_oscillator_out,
                       pulse_width_out, capture_compare_unit_out,
                       high_carrier_pin, low_carrier_pin, modulator_pin};

  dsm_sync #(.WIDTH(DSM_SYNC_WIDTH)) u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (raw_bundle),
    .sync_out (sync_bundle)
  );

  // named views of the synchronised bundle
  wire       s_mod_pin  = sync_bundle[0];
  wire       s_low_pin  = sync_bundle[1];
  wire       s_high_pin = sync_bundle[2];
  wire [4:0] s_capcomp  = sync_bundle[7:3];
  wire [1:0] s_pwm      = sync_bundle[9:8];
  wire       s_num_osc  = sync_bundle[10];
  wire       s_cmp1     = sync_bundle[11];
  wire       s_cmp2     = sync_bundle[12];
  wire [3:0] s_cell     = sync_bundle[16:13];
  wire [1:0] s_tx       = sync_bundle[18:17];
  wire [1:0] s_sdo      = sync_bundle[20:19];
  wire       s_fast_osc = sync_bundle[21];
  wire       s_ref_clk  = sync_bundle[22];

  // ==========================================================================
  // registers
  // ==========================================================================
  logic       enable_reg;          // module enable
  logic       out_invert_reg;      // output_invert
  logic       sw_level_reg;        // software_modulation_source
  logic [7:0] carrier_ctrl_reg;    // carrier_polarity_sync_control
  logic [4:0] mod_src_reg;         // modulator_source_select
  logic [3:0] low_src_reg;         // low_carrier_select
  logic [3:0] high_src_reg;        // high_carrier_select
  logic       ack_reg;             // bus access completing
  logic [31:0] readdata_reg;       // registered read answer
  logic       out_reg;             // modulated output flop
  logic       active_high_reg;     // carrier currently mixed is high one
  logic       low_prev_reg;        // previous low carrier level
  logic       high_prev_reg;       // previous high carrier level
  logic       sys_clk_reg;         // system clock stand-in, toggles each edge

  // ==========================================================================
  // avalon-mm decode
  // ==========================================================================
  wire        request   = read | write;              // access pending
  wire [11:0] word_idx  = address[DSM_ADDR_W-1:2];   // word index
  wire        hit_ctl0  = (word_idx == DSM_IDX_CONTROL0);
  wire        hit_cctl  = (word_idx == DSM_IDX_CARRIER_CTRL);
  wire        hit_msrc  = (word_idx == DSM_IDX_MOD_SRC);
  wire        hit_lsrc  = (word_idx == DSM_IDX_LOW_SRC);
  wire        hit_hsrc  = (word_idx == DSM_IDX_HIGH_SRC);
  wire        wr_commit = write & ack_reg & byteenable[0]; // write takes effect
  wire [7:0]  wbyte     = writedata[7:0];

  // one wait state: waitrequest drops in the cycle after the request rises
  assign waitrequest = request & ~ack_reg;
  assign readdata    = readdata_reg;

  // read word assembly; unmapped addresses read as zero
  wire [7:0] ctl0_view = {enable_reg, 1'b0, out_reg, out_invert_reg, 3'b000, sw_level_reg};
  wire [7:0] rd_byte   = hit_ctl0 ? ctl0_view :
                         hit_cctl ? carrier_ctrl_reg :
                         hit_msrc ? {3'b000, mod_src_reg} :
                         hit_lsrc ? {4'h0, low_src_reg} :
                         hit_hsrc ? {4'h0, high_src_reg} : 8'h00;

  // access handshake and read capture
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= request & ~ack_reg;
      if (read & ~ack_reg) begin
        readdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // software registers; selections survive a cleared enable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_reg       <= DSM_RST_CONTROL0[DSM_BIT_ENABLE];
      out_invert_reg   <= DSM_RST_CONTROL0[DSM_BIT_OUT_INVERT];
      sw_level_reg     <= DSM_RST_CONTROL0[DSM_BIT_SW_LEVEL];
      carrier_ctrl_reg <= DSM_RST_CARRIER_CTRL;
      mod_src_reg      <= DSM_RST_MOD_SRC;
      low_src_reg      <= DSM_RST_CARRIER_SRC;
      high_src_reg     <= DSM_RST_CARRIER_SRC;
    end else if (wr_commit) begin
      if (hit_ctl0) begin
        enable_reg     <= wbyte[DSM_BIT_ENABLE];
        out_invert_reg <= wbyte[DSM_BIT_OUT_INVERT];
        sw_level_reg   <= wbyte[DSM_BIT_SW_LEVEL];
      end
      if (hit_cctl) begin
        carrier_ctrl_reg <= wbyte & 8'h33;  // four implemented bits only
      end
      if (hit_msrc) begin
        mod_src_reg <= wbyte[4:0];
      end
      if (hit_lsrc) begin
        low_src_reg <= wbyte[3:0];
      end
      if (hit_hsrc) begin
        high_src_reg <= wbyte[3:0];
      end
    end
  end

  wire high_invert = carrier_ctrl_reg[DSM_BIT_HIGH_INVERT];
  wire high_sync   = carrier_ctrl_reg[DSM_BIT_HIGH_SYNC];
  wire low_invert  = carrier_ctrl_reg[DSM_BIT_LOW_INVERT];
  wire low_sync    = carrier_ctrl_reg[DSM_BIT_LOW_SYNC];

  // ==========================================================================
  // keying source select
  // ==========================================================================
  logic [DSM_MSRC_COUNT-1:0] mod_sources; // indexed by source code
  logic                      keying_signal;

  assign mod_sources = {s_tx[1], s_capcomp[4], s_sdo[1], s_sdo[0], s_tx[0], s_cell,
                        s_cmp2, s_cmp1, s_num_osc, s_pwm, s_capcomp[3:0],
                        sw_level_reg, s_mod_pin};

  // reserved codes give a steady low keying level
  // software level used only under its own code
  assign keying_signal = (mod_src_reg > DSM_MSRC_LAST) ? 1'b0 : mod_sources[mod_src_reg];

  // ==========================================================================
  // carrier paths
  // ==========================================================================
  logic [DSM_CARRIER_COUNT-1:0] carrier_sources; // shared carrier table
  logic                         low_carrier;
  logic                         high_carrier;

  // system clock stand-in toggles every edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_clk_reg <= 1'b0;
    end else begin
      sys_clk_reg <= ~sys_clk_reg;
    end
  end

  // codes above zero common to both carriers
  assign carrier_sources[15:1] = {s_capcomp[4], s_cell, s_num_osc, s_pwm, s_capcomp[3:0],
                                  s_ref_clk, s_fast_osc, sys_clk_reg};
  assign carrier_sources[0]    = 1'b0; // code zero replaced by each pin

  dsm_carrier_path u_low (
    .sources ({carrier_sources[15:1], s_low_pin}),
    .select  (low_src_reg),
    .invert  (low_invert),
    .carrier (low_carrier)
  );

  dsm_carrier_path u_high (
    .sources ({carrier_sources[15:1], s_high_pin}),
    .select  (high_src_reg),
    .invert  (high_invert),
    .carrier (high_carrier)
  );

  // ==========================================================================
  // carrier switching with optional synchronisation
  // ==========================================================================
  wire low_fall  = low_prev_reg & ~low_carrier;   // low carrier falling edge
  wire high_fall = high_prev_reg & ~high_carrier; // high carrier falling edge
  logic active_high_next;

  // switch at once, or wait for the old carrier to fall
  always_comb begin
    active_high_next = active_high_reg;
    if (keying_signal && !active_high_reg) begin
      if (!low_sync || low_fall) begin
        active_high_next = 1'b1;
      end
    end else if (!keying_signal && active_high_reg) begin
      if (!high_sync || high_fall) begin
        active_high_next = 1'b0;
      end
    end
  end

  // carrier state and edge history
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      active_high_reg <= 1'b0;
      low_prev_reg    <= 1'b0;
      high_prev_reg   <= 1'b0;
    end else begin
      active_high_reg <= active_high_next;
      low_prev_reg    <= low_carrier;
      high_prev_reg   <= high_carrier;
    end
  end

  // ==========================================================================
  // mixing and output
  // ==========================================================================
  // mix the carrier chosen by the keying state
  wire mix     = active_high_reg ? high_carrier : low_carrier;
  // disabled pin low, otherwise optional inversion
  wire out_val = enable_reg & (mix ^ out_invert_reg);

  // output flop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_val;
    end
  end

  assign modulated_output_pin = out_reg;

  // ==========================================================================
  // assertions
  // ==========================================================================
  sequence keying_rise_s;
    keying_signal && !active_high_reg;
  endsequence

  sequence no_low_fall_s;
    !low_fall;
  endsequence

  // output low after a cleared enable
  disabled_low_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !enable_reg |=> !modulated_output_pin)
    else $error("output not low while disabled");

  mix_follow_a: assert property (
    @(posedge clock) disable iff (!resetn)
    enable_reg && !out_invert_reg |=> modulated_output_pin == $past(mix))
    else $error("output does not follow carrier");

  out_invert_a: assert property (
    @(posedge clock) disable iff (!resetn)
    enable_reg && out_invert_reg && !mix |=> modulated_output_pin)
    else $error("inverted output not high");

  sw_level_a: assert property (
    @(posedge clock) disable iff (!resetn)
    mod_src_reg == DSM_MSRC_SW_LEVEL && sw_level_reg && !low_sync |=> active_high_reg)
    else $error("software level ignored");

  reserved_low_a: assert property (
    @(posedge clock) disable iff (!resetn)
    mod_src_reg > DSM_MSRC_LAST && !high_sync |=> !active_high_reg)
    else $error("reserved code not low");

  nosync_switch_a: assert property (
    @(posedge clock) disable iff (!resetn)
    keying_rise_s and !low_sync |=> active_high_reg)
    else $error("switch to high carrier late");

  // synchronised switch waits for low carrier fall
  sync_wait_a: assert property (
    @(posedge clock) disable iff (!resetn)
    keying_rise_s and low_sync and no_low_fall_s |=> !active_high_reg)
    else $error("switched before low carrier fell");

  // synchronised switch back waits for high carrier fall
  high_wait_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !keying_signal && active_high_reg && high_sync && !high_fall |=> active_high_reg)
    else $error("switched before high carrier fell");

  // unimplemented carrier control bits stay zero
  ctrl_bits_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (carrier_ctrl_reg & 8'hCC) == 8'h00)
    else $error("unimplemented control bit set");

  // bus answers after one wait state
  bus_answer_a: assert property (
    @(posedge clock) disable iff (!resetn)
    request && !ack_reg |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait");

endmodule : dsm_top

// ---- testbench/dsm_src_model.sv ----
// dsm_src_model: stands in for the peripherals, clocks and pins that feed the modulator
// assumes: the bench sets level; every source changes just after a rising edge
`timescale 1ns/1ps
module dsm_src_model (
  input  wire logic        clock,
  input  wire logic [22:0] level,
  output logic      [22:0] src
);
  // ==========================================================================
  // source outputs
  // ==========================================================================
  logic [22:0] src_reg = 23'h000000; // sources start low so no input is unknown

  // sources launch after the edge, like any peripheral flop
  always @(posedge clock) begin
    src_reg <= level;
  end

  assign src = src_reg;
endmodule : dsm_src_model

// ---- testbench/tb_data_signal_modulator_select.sv ----
// tb_data_signal_modulator_select: self-checking bench for dsm_top
// assumes: dsm_src_model drives all sources; registers reached over avalon-mm
`timescale 1ns/1ps
module tb_data_signal_modulator_select;
  import dsm_pkg::*;
  // ==========================================================================
  // signals and model state
  // ==========================================================================
  logic        clock;
  logic        resetn = 1'b0;
  logic [13:0] address = 14'h0000;
  logic        read = 1'b0, write = 1'b0, waitrequest, mout;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h00000000, readdata;
  logic [22:0] level = 23'h000000, src;
  logic [7:0]  q;
  int fail_count = 0, n_checks = 0, cyc = 0;
  int m[5]; // mirrored registers, index from control0
  int ktab[$] = {0, -1, 3, 4, 5, 6, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 19, 20, 7, 18};
  int ctab[$] = {-1, -1, 21, 22, 3, 4, 5, 6, 8, 9, 10, 13, 14, 15, 16, 7};

  dsm_src_model far (.clock(clock), .level(level), .src(src));
  dsm_top uut (.clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .modulator_pin(src[0]), .low_carrier_pin(src[1]),
    .high_carrier_pin(src[2]), .capture_compare_unit_out(src[7:3]),
    .pulse_width_out(src[9:8]), .numeric_oscillator_out(src[10]),
    .comparator_one_out(src[11]), .comparator_two_out(src[12]),
    .configurable_logic_cell_out(src[16:13]), .enhanced_serial_port_tx(src[18:17]),
    .sync_serial_port_sdo(src[20:19]), .fast_internal_oscillator(src[21]),
    .reference_clock_output(src[22]), .modulated_output_pin(mout));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ==========================================================================
  // reporting
  // ==========================================================================
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("Error at %0t: run timed out", $time);
      close_out();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // ==========================================================================
  // bus tasks and reference model
  // ==========================================================================
  // request held until waitrequest is low at a rising edge
  task automatic bus(input int i, input bit wr, input logic [7:0] d, input logic [3:0] be);
    @(posedge clock);
    address <= 14'(i * 4);
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, d};
    byteenable <= be;
    // waitrequest is judged as it stands at each rising edge
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic setr(input int r, input int d);
    bus(DSM_IDX_CONTROL0 + r, 1'b1, 8'(d), 4'hF);
    m[r] = d;
  endtask : setr

  task automatic getr(input int r, input int e, input string w);
    bus(DSM_IDX_CONTROL0 + r, 1'b0, 8'h00, 4'hF);
    chk(q, 8'(e), w);
  endtask : getr

  function automatic bit keyv();
    if (m[2] == 1) return m[0][0]; // software level
    if (m[2] >= 20) return 1'b0;   // reserved codes key low
    return level[ktab[m[2]]];
  endfunction : keyv

  function automatic bit carr(input int c, input int pin);
    return (c == 0) ? level[pin] : level[ctab[c]];
  endfunction : carr

  function automatic logic [7:0] expo(input bit st);
    bit mix;
    mix = st ? (carr(m[4], 2) ^ m[1][5]) : (carr(m[3], 1) ^ m[1][1]);
    return 8'(m[0][7] & (mix ^ m[0][4]));
  endfunction : expo

  // let sources cross the synchroniser and the output flop
  task automatic look(input bit st, input string w);
    repeat (8) @(posedge clock);
    chk({7'h00, mout}, expo(st), w);
  endtask : look

  // keying change while one carrier is high, then that carrier falls
  task automatic sync_case(input int ctl, input int pb, input bit k0);
    setr(1, ctl);
    setr(3, k0 ? 2 : 0);
    setr(4, k0 ? 0 : 2);
    level <= 23'(1 << pb);
    setr(0, 'h80 | k0);
    look(k0, "before keying change");
    setr(0, 'h80 | !k0);
    look(k0, "held on old carrier");
    level <= 23'h000000;
    look(!k0, "switched after fall");
    level <= 23'(1 << pb);
    look(!k0, "stays on new carrier");
  endtask : sync_case

  // ==========================================================================
  // test sequence
  // ==========================================================================
  initial begin
    void'($urandom(87043));
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    for (int r = 0; r < 5; r++) getr(r, 0, "reset value");
    getr(-1, 0, "unmapped read");
    setr(1, 'hFF);
    getr(1, 'h33, "carrier control bits");
    bus(DSM_IDX_CARRIER_CTRL, 1'b1, 8'h00, 4'h0);
    getr(1, 'h33, "write without byte lane");
    setr(1, 0);
    $display("test registers done");
    setr(3, 2);
    setr(4, 3);
    for (int k = 0; k < 32; k++) begin
      setr(2, k);
      getr(2, k, "keying select");
      repeat (2) begin
        level <= (23'($urandom) & 23'h1FFFFF) | 23'h400000;
        setr(0, 'h80 | ($urandom & 1));
        look(keyv(), "keying path");
      end
    end
    $display("test keying done");
    setr(2, 1);
    for (int c = 0; c < 16; c++) begin
      // system clock carrier toggles every edge: output flips each cycle
      if (c == 1) begin
        setr(3, 1);
        setr(0, 'h80);
        repeat (8) @(posedge clock);
        q = {7'h00, mout};
        @(posedge clock);
        chk({7'h00, mout}, ~q & 8'h01, "system clock carrier");
        continue;
      end
      setr(3, c);
      setr(4, c);
      repeat (2) begin
        level <= 23'($urandom);
        setr(1, $urandom & 'h22);
        setr(0, 'h80 | ($urandom & 1));
        look(keyv(), "carrier path");
      end
    end
    $display("test carriers done");
    setr(1, 0);
    setr(3, 2);
    setr(4, 5);
    level <= 23'h000000;
    setr(0, 'h90);
    look(0, "idle inverted");
    getr(0, 'hB0, "output state bit");
    setr(0, 'h10);
    look(0, "disabled low");
    getr(4, 5, "selection kept");
    setr(0, 'h90);
    look(0, "resumed");
    $display("test enable done");
    sync_case('h01, 1, 1'b0);
    sync_case('h10, 2, 1'b1);
    $display("test sync done");
    close_out();
  end
endmodule : tb_data_signal_modulator_select
